/* stc_pkg.sv */
/*
  Shared constants for the stripe track decoder: register map, field
  positions, track formats and decoder states.
  Assumes a single core clock domain and a plain register port.
*/
package stc_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int BIT_AW = 10;
  localparam int BIT_DEPTH = 1024;
  localparam int CHR_AW = 7;
  localparam int CHR_DEPTH = 128;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_CHAR = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_BITS = 4'hc;
  localparam logic [3:0] CTRL_RESET = 4'h1;
  localparam int CTRL_PAR = 2;
  localparam int CTRL_BIDIR = 3;
  localparam int STB_CARD = 0;
  localparam int STB_BUSY = 1;
  localparam int STB_DONE = 2;
  localparam int STB_PAR = 3;
  localparam int STB_LRC = 4;
  localparam int STB_NOMARK = 5;
  localparam int STB_REV = 6;
  localparam int STB_NCHR = 8;
  // ****************************************
  // Track formats
  // ****************************************
  localparam logic [1:0] TRK1 = 2'h0;
  localparam logic [2:0] WLAST_ALPHA = 3'h6;
  localparam logic [2:0] WLAST_NUM = 3'h4;
  // Start markers written parity first, most significant bit first
  localparam logic [6:0] START_ALPHA = 7'h45;
  localparam logic [4:0] START_NUM = 5'h0b;
  localparam logic [5:0] END_ALPHA = 6'h1f;
  localparam logic [3:0] END_NUM = 4'hf;
  localparam logic [5:0] FIELD_ALPHA = 6'h3e;
  localparam logic [3:0] FIELD_NUM = 4'hd;
  localparam logic [7:0] ASC_ALPHA = 8'h20;
  localparam logic [7:0] ASC_NUM = 8'h30;
  typedef enum logic [2:0] {
    ST_IDLE, ST_CAPTURE, ST_HUNT, ST_FRAME, ST_DONE
  } stc_state_e;
endpackage

/* stc_link_if.sv */
/*
  Bit stream from the pin front end to the decoder core.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
interface stc_link_if;
  logic card_present;
  logic bit_valid;
  logic bit_val;
  modport front (output card_present, output bit_valid, output bit_val);
  modport core (input card_present, input bit_valid, input bit_val);
endinterface

/* stc_front.sv */
/*
  Pin front end: synchronises the reader's card-sensed, strobe and data
  lines and turns each strobe falling edge into a one-cycle bit pulse.
  Assumes the reader lines rest high and may change at any time.
*/
`timescale 1ns/1ps
module stc_front
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Reader pins
  input  wire logic card_sense_n,
  input  wire logic strobe_n,
  input  wire logic data_n,
  // Bit stream
  stc_link_if.front lk
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic       strobe_prev;
    logic       card;
    logic       valid;
    logic       bit_val;
  } stc_front_s;

  stc_front_s q;
  stc_front_s next_q;

  always_comb
  begin
    next_q = q;
    next_q.s1 = {card_sense_n, strobe_n, data_n};
    next_q.s2 = q.s1;
    next_q.strobe_prev = q.s2[1];
    next_q.card = !q.s2[2];
    // Falling strobe edge is the bit clock; low data is a one
    next_q.valid = q.strobe_prev && !q.s2[1];
    next_q.bit_val = !q.s2[0];
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      q <= '{s1: 3'h7, s2: 3'h7, strobe_prev: 1'h1, default: '0};
    else
      q <= next_q;
  end

  assign lk.card_present = q.card;
  assign lk.bit_valid = q.valid;
  assign lk.bit_val = q.bit_val;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  chk_bit_polarity: assert property (
    $fell(q.s2[1]) |=> lk.bit_valid && (lk.bit_val == !$past(q.s2[0])))
    else $error("bit value does not follow the data line at the strobe edge");
endmodule

/* stc_decoder.sv */
/*
  Stripe track decoder: captures the reader's bit stream while a card is
  present, then hunts the start marker, frames characters, checks odd
  parity and the longitudinal check, retries in reverse when enabled and
  offers ASCII characters on a small register port.
  Assumes a reader that drives active-low card-sensed, strobe and data.
*/
// Operation
// - Track 1 characters are six data bits plus odd parity.
// - Track 2 and 3 characters are four data bits plus odd parity.
// - Characters arrive least significant bit first, parity last.
// - Track 2 start marker is serial 11010, value 0Bh.
// - Track holds zeros, start, data, end marker, check character, zeros.
// - Check character equals XOR of all data bits incl. both markers.
// - Check character parity is its own odd parity.
// - Parity and check tests run after the card has left.
// - Card-sensed, data and strobe are active low.
// - A bit is taken on the strobe falling edge.
// - Start detection includes leading zeros: four zeros plus marker.
// - Framing starts only after the start marker matches.
// - Track 1 passes six data bits with parity checked, or seven raw.
// - Tracks 2 and 3 pass the five-bit word including parity.
// - Raw bits are stored and searched; else search reversed.
// - Start match followed by end marker is a false hit; reverse.
// - Unreadable only after both directions fail.
// - Bidirectional capture starts at the first one bit.
// - Track 1 ASCII is data plus 20h.
// - Track 2 and 3 ASCII is data plus 30h.
// - Data high at strobe is a zero, low is a one.
`timescale 1ns/1ps
module stc_decoder
(
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        reset_n,
  // Reader pins
  input  wire logic                        card_sense_n,
  input  wire logic                        strobe_n,
  input  wire logic                        data_n,
  // Register port
  input  wire logic [stc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [stc_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [stc_pkg::DATA_W-1:0] reg_rdata
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    stc_pkg::stc_state_e st;
    logic [3:0]          ctrl;
    logic [10:0]         nbits;
    logic [10:0]         pos;
    logic [10:0]         left;
    logic                rev;
    logic                seen_one;
    logic [15:0]         sh;
    logic [6:0]          wd;
    logic [2:0]          wcnt;
    logic [5:0]          lrc;
    logic                first;
    logic                got_end;
    logic [7:0]          nchr;
    logic [6:0]          rd_idx;
    logic                par_err;
    logic                lrc_err;
    logic                nomark;
    logic [15:0]         rdata;
  } stc_core_s;

  stc_core_s q;
  stc_core_s next_q;

  stc_link_if lk ();

  stc_front u_front
  (
    .core_clk     (core_clk),
    .reset_n      (reset_n),
    .card_sense_n (card_sense_n),
    .strobe_n     (strobe_n),
    .data_n       (data_n),
    .lk           (lk.front)
  );

  // Raw bits kept whole so the stream can be walked either way
  logic        bmem [stc_pkg::BIT_DEPTH];
  logic [15:0] cmem [stc_pkg::CHR_DEPTH];

  logic        alpha;
  logic [2:0]  w_last;
  logic        cur;
  logic [15:0] sh_n;
  logic [6:0]  wd_n;
  logic [5:0]  dat;
  logic [5:0]  endc;
  logic [5:0]  startc;
  logic        hit;
  logic        par_ok;
  logic        char_done;
  logic [7:0]  ascii;
  logic [7:0]  raw;
  logic        bm_we;
  logic        cm_we;
  logic        fail;
  logic        pass;
  logic [15:0] stat;

  // ****************************************
  // Character decode
  // ****************************************
  always_comb
  begin
    alpha = q.ctrl[1:0] == stc_pkg::TRK1;
    w_last = alpha ? stc_pkg::WLAST_ALPHA : stc_pkg::WLAST_NUM;
    cur = bmem[q.pos[9:0]];
    sh_n = {cur, q.sh[15:1]};
    // New bits enter at the top, so a finished character sits
    // with bit 0 lowest and parity highest
    wd_n = alpha ? {cur, q.wd[6:1]} : {2'h0, cur, q.wd[4:1]};
    dat = alpha ? wd_n[5:0] : {2'h0, wd_n[3:0]};
    endc = alpha ? stc_pkg::END_ALPHA : {2'h0, stc_pkg::END_NUM};
    startc = alpha ? stc_pkg::START_ALPHA[5:0] : {2'h0, stc_pkg::START_NUM[3:0]};
    // Four leading zeros ahead of the marker keep blank-track noise out
    if (alpha)
      hit = sh_n[15:9] == stc_pkg::START_ALPHA && sh_n[8:5] == 4'h0;
    else
      hit = sh_n[15:11] == stc_pkg::START_NUM && sh_n[10:7] == 4'h0;
    par_ok = ^wd_n;
    char_done = q.st == stc_pkg::ST_FRAME && q.wcnt == w_last;
    ascii = {2'h0, dat} + (alpha ? stc_pkg::ASC_ALPHA : stc_pkg::ASC_NUM);
    if (alpha && q.ctrl[stc_pkg::CTRL_PAR])
      raw = {2'h0, dat};
    else
      raw = {1'h0, wd_n};
  end

  // ****************************************
  // Control
  // ****************************************
  always_comb
  begin
    next_q = q;
    bm_we = 1'h0;
    cm_we = 1'h0;
    fail = 1'h0;
    pass = 1'h0;
    case (q.st)
      stc_pkg::ST_IDLE, stc_pkg::ST_DONE:
      begin
        if (lk.card_present)
        begin
          next_q.st = stc_pkg::ST_CAPTURE;
          next_q.nbits = '0;
          next_q.seen_one = 1'h0;
          next_q.nchr = '0;
          next_q.rd_idx = '0;
          next_q.rev = 1'h0;
          next_q.par_err = 1'h0;
          next_q.lrc_err = 1'h0;
          next_q.nomark = 1'h0;
        end
      end
      stc_pkg::ST_CAPTURE:
      begin
        // In bidirectional mode the leading zeros are not kept
        if (lk.bit_valid && !q.nbits[10]
            && (!q.ctrl[stc_pkg::CTRL_BIDIR] || q.seen_one || lk.bit_val))
        begin
          bm_we = 1'h1;
          next_q.nbits = q.nbits + 11'h1;
          next_q.seen_one = 1'h1;
        end
        if (!lk.card_present)
        begin
          next_q.st = stc_pkg::ST_HUNT;
          next_q.pos = '0;
          next_q.left = q.nbits;
          next_q.sh = '0;
        end
      end
      stc_pkg::ST_HUNT:
      begin
        if (q.left == 11'h0)
        begin
          next_q.nomark = 1'h1;
          fail = 1'h1;
        end
        else
        begin
          next_q.pos = q.rev ? q.pos - 11'h1 : q.pos + 11'h1;
          next_q.left = q.left - 11'h1;
          next_q.sh = sh_n;
          if (hit)
          begin
            next_q.st = stc_pkg::ST_FRAME;
            next_q.lrc = startc;
            next_q.wd = '0;
            next_q.wcnt = '0;
            next_q.first = 1'h1;
            next_q.got_end = 1'h0;
          end
        end
      end
      stc_pkg::ST_FRAME:
      begin
        if (q.left == 11'h0)
        begin
          next_q.nomark = 1'h1;
          fail = 1'h1;
        end
        else
        begin
          next_q.pos = q.rev ? q.pos - 11'h1 : q.pos + 11'h1;
          next_q.left = q.left - 11'h1;
          next_q.wd = wd_n;
          next_q.wcnt = q.wcnt + 3'h1;
          if (char_done)
          begin
            next_q.wcnt = '0;
            next_q.first = 1'h0;
            next_q.wd = '0;
            if (!par_ok)
              next_q.par_err = 1'h1;
            if (q.got_end)
            begin
              // Character after the end marker is the check character
              next_q.lrc_err = dat != q.lrc;
              if (dat != q.lrc || !par_ok || q.par_err)
                fail = 1'h1;
              else
                pass = 1'h1;
            end
            else if (q.first && dat == endc)
            begin
              // Check character looked like a start marker
              next_q.nomark = 1'h1;
              fail = 1'h1;
            end
            else
            begin
              next_q.lrc = q.lrc ^ dat;
              if (dat == endc)
                next_q.got_end = 1'h1;
              else if (!q.nchr[7])
              begin
                cm_we = 1'h1;
                next_q.nchr = q.nchr + 8'h1;
              end
            end
          end
        end
      end
      default:
        next_q.st = stc_pkg::ST_IDLE;
    endcase

    // A failed forward pass is retried from the far end
    if (fail)
    begin
      if (q.ctrl[stc_pkg::CTRL_BIDIR] && !q.rev)
      begin
        next_q.st = stc_pkg::ST_HUNT;
        next_q.rev = 1'h1;
        next_q.pos = q.nbits - 11'h1;
        next_q.left = q.nbits;
        next_q.sh = '0;
        next_q.nchr = '0;
        next_q.par_err = 1'h0;
        next_q.lrc_err = 1'h0;
        next_q.nomark = 1'h0;
      end
      else
        next_q.st = stc_pkg::ST_DONE;
    end
    if (pass)
      next_q.st = stc_pkg::ST_DONE;

    // Register port
    if (reg_wr && reg_addr == stc_pkg::OFF_CTRL)
      next_q.ctrl = reg_wdata[3:0];
    if (reg_wr && reg_addr == stc_pkg::OFF_CHAR)
      next_q.rd_idx = reg_wdata[6:0];
    next_q.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        stc_pkg::OFF_CTRL:
          next_q.rdata = {12'h000, q.ctrl};
        stc_pkg::OFF_STATUS:
          next_q.rdata = stat;
        stc_pkg::OFF_CHAR:
        begin
          next_q.rdata = cmem[q.rd_idx];
          next_q.rd_idx = q.rd_idx + 7'h1;
        end
        stc_pkg::OFF_BITS:
          next_q.rdata = {5'h00, q.nbits};
        default:
          next_q.rdata = '0;
      endcase
    end
  end

  // Error flags only show once decoding has finished
  always_comb
  begin
    stat = '0;
    stat[stc_pkg::STB_CARD] = lk.card_present;
    stat[stc_pkg::STB_BUSY] = q.st != stc_pkg::ST_IDLE && q.st != stc_pkg::ST_DONE;
    stat[stc_pkg::STB_DONE] = q.st == stc_pkg::ST_DONE;
    stat[stc_pkg::STB_PAR] = stat[stc_pkg::STB_DONE] && q.par_err;
    stat[stc_pkg::STB_LRC] = stat[stc_pkg::STB_DONE] && q.lrc_err;
    stat[stc_pkg::STB_NOMARK] = stat[stc_pkg::STB_DONE] && q.nomark;
    stat[stc_pkg::STB_REV] = q.rev;
    stat[15:stc_pkg::STB_NCHR] = q.nchr;
  end

  // ****************************************
  // Registers and memories
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      q <= '{st: stc_pkg::ST_IDLE, ctrl: stc_pkg::CTRL_RESET, default: '0};
    else
      q <= next_q;
  end

  always_ff @(posedge core_clk)
  begin
    if (bm_we)
      bmem[q.nbits[9:0]] <= lk.bit_val;
    if (cm_we)
      cmem[q.nchr[6:0]] <= {raw, ascii};
  end

  assign reg_rdata = q.rdata;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  chk_bit_capture: assert property (
    q.st == stc_pkg::ST_CAPTURE && lk.bit_valid && lk.card_present && !q.nbits[10]
    && !q.ctrl[stc_pkg::CTRL_BIDIR] |=> q.nbits == $past(q.nbits) + 11'h1)
    else $error("strobed bit was not stored");

  chk_first_one: assert property (
    q.st == stc_pkg::ST_CAPTURE && q.ctrl[stc_pkg::CTRL_BIDIR] && !q.seen_one
    && lk.bit_valid && !lk.bit_val |=> q.nbits == 11'h0)
    else $error("leading zero stored in bidirectional mode");

  chk_check_after_exit: assert property (
    q.st == stc_pkg::ST_CAPTURE && !lk.card_present |=> q.st == stc_pkg::ST_HUNT
    ##1 q.st != stc_pkg::ST_CAPTURE)
    else $error("decoding did not start after the card left");

  chk_sync_match: assert property (
    q.st == stc_pkg::ST_HUNT && q.left != 11'h0 && hit
    |=> q.st == stc_pkg::ST_FRAME && q.wcnt == 3'h0 && q.lrc == $past(startc))
    else $error("start marker match did not begin framing");

  chk_frame_width: assert property (
    q.st == stc_pkg::ST_FRAME && q.left != 11'h0
    |=> q.st != stc_pkg::ST_FRAME
    || q.wcnt == (($past(q.wcnt) == $past(w_last)) ? 3'h0 : $past(q.wcnt) + 3'h1))
    else $error("character framing does not follow the track width");

  chk_lrc_compare: assert property (
    char_done && q.left != 11'h0 && q.got_end && dat != q.lrc
    |=> (q.lrc_err && q.st == stc_pkg::ST_DONE) || (q.st == stc_pkg::ST_HUNT && q.rev))
    else $error("check character mismatch not reported");

  chk_lrc_parity: assert property (
    char_done && q.left != 11'h0 && q.got_end && !par_ok
    && (q.rev || !q.ctrl[stc_pkg::CTRL_BIDIR])
    |=> q.par_err && q.st == stc_pkg::ST_DONE)
    else $error("check character parity error not reported");

  chk_false_hit: assert property (
    char_done && q.left != 11'h0 && !q.got_end && q.first && dat == endc
    && q.ctrl[stc_pkg::CTRL_BIDIR] && !q.rev
    |=> q.st == stc_pkg::ST_HUNT && q.rev && q.left == q.nbits)
    else $error("false start hit did not reverse the search");

  chk_flags_hidden: assert property (
    q.st == stc_pkg::ST_CAPTURE |-> stat[5:3] == 3'h0 && !stat[stc_pkg::STB_DONE])
    else $error("error flags visible while the card is present");

  chk_ascii_store: assert property (
    cm_we |-> (alpha ? (ascii >= 8'h20 && ascii <= 8'h5f) : (ascii[7:4] == 4'h3)))
    else $error("ascii offset wrong for the track");

  cov_forward_pass: cover property (
    q.st == stc_pkg::ST_FRAME && pass && !q.rev);
  cov_reverse_pass: cover property (
    q.st == stc_pkg::ST_FRAME && pass && q.rev);
  cov_unreadable: cover property (
    fail && q.rev);
  cov_char_read: cover property (
    reg_rd && reg_addr == stc_pkg::OFF_CHAR && q.nchr != 8'h0);
endmodule

/* stc_reader_model.sv */
/*
  Behavioural model of the card reader's read/decode circuit: swipes a
  given bit stream out on the card-sensed, strobe and data lines.
  Assumes the caller hands it a whole track, bit 0 first.
*/
`timescale 1ns/1ps
module stc_reader_model
#(
  parameter int BIT_NS  = 800,
  parameter int LEAD_NS = 3000,
  parameter int REL_NS  = 5000
)
(
  // Reader pins
  output logic card_sense_n,
  output logic strobe_n,
  output logic data_n
);
  // ****************************************
  // Idle levels
  // ****************************************
  initial
  begin
    card_sense_n = 1'b1;
    strobe_n     = 1'b1;
    data_n       = 1'b1;
  end
  // ****************************************
  // One swipe
  // ****************************************
  // Odd offset keeps the strobe edges out of phase with the core clock
  task automatic swipe(input logic [1023:0] b, input int n);
    card_sense_n = 1'b0;
    #(LEAD_NS + 37);
    for (int i = 0; i < n; i++)
    begin
      data_n = ~b[i];
      #(BIT_NS / 4) strobe_n = 1'b0;
      #(BIT_NS / 2) strobe_n = 1'b1;
      // Hold time is over: show garbage rather than the old bit
      #(BIT_NS / 8) data_n = ~data_n;
      #(BIT_NS / 8);
    end
    data_n = 1'b1;
    // Release delay shortened from the real figure to keep runs short
    #(REL_NS) card_sense_n = 1'b1;
  endtask
endmodule

/* stc_decoder_tb_top.sv */
/*
  Self-checking bench for the stripe track decoder: builds tracks, swipes
  them through the reader model and checks status, bit count and chars.
  Assumes the register port and reader model described in the design.
*/
`timescale 1ns/1ps
module stc_decoder_tb_top;
  // ****************************************
  // Signals
  // ****************************************
  logic                        core_clk  = 1'b0;
  logic                        reset_n   = 1'b0;
  logic [stc_pkg::ADDR_W-1:0] reg_addr  = '0;
  logic [stc_pkg::DATA_W-1:0] reg_wdata = '0;
  logic                        reg_wr    = 1'b0;
  logic                        reg_rd    = 1'b0;
  logic [stc_pkg::DATA_W-1:0] reg_rdata;
  wire                         card_sense_n;
  wire                         strobe_n;
  wire                         data_n;
  int                          n_errors   = 0;
  int                          n_compared = 0;
  logic [31:0]                 lfsr = 32'hbec728e8;
  logic [1023:0]               bits;
  logic [1023:0]               sent;
  int                          nb;
  logic [7:0]                  raws[$];
  logic [15:0]                 modes[4] = '{16'h0004, 16'h0000, 16'h0001, 16'h0002};

  always #50 core_clk = ~core_clk;

  stc_decoder i_stc_decoder (.core_clk(core_clk), .reset_n(reset_n),
    .card_sense_n(card_sense_n), .strobe_n(strobe_n), .data_n(data_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  stc_reader_model i_stc_reader_model (.card_sense_n(card_sense_n),
    .strobe_n(strobe_n), .data_n(data_n));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic odd_par(input logic [5:0] d, input int w);
    return ~(^(d & 6'((1 << w) - 1)));
  endfunction

  function automatic logic [15:0] exp_char(input logic [15:0] ctrl, input logic [7:0] raw);
    logic       t1;
    logic [7:0] asc;
    t1  = (ctrl[1:0] == 2'h0);
    asc = t1 ? (raw & 8'h3f) + 8'h20 : (raw & 8'h0f) + 8'h30;
    return {(t1 && ctrl[2]) ? (raw & 8'h3f) : raw, asc};
  endfunction

  task automatic print_verdict;
    if (n_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      n_errors++;
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // ****************************************
  // Track builder
  // ****************************************
  task automatic put(input logic [5:0] d, input int w, input logic bad);
    for (int i = 0; i < w; i++)
    begin
      bits[nb] = d[i];
      nb++;
    end
    bits[nb] = odd_par(d, w) ^ bad;
    nb++;
  endtask

  task automatic build(input bit t1, input int n, input int bad, input logic [5:0] lrc_err);
    logic [5:0] d;
    logic [5:0] lrc;
    logic [5:0] env;
    int         w;
    w    = t1 ? 6 : 4;
    env  = t1 ? 6'h1f : 6'h0f;
    bits = '0;
    nb   = 8;
    raws.delete();
    put(t1 ? 6'h05 : 6'h0b, w, 1'b0);
    lrc = t1 ? 6'h05 : 6'h0b;
    for (int i = 0; i < n; i++)
    begin
      lfsr = lfsr_next(lfsr);
      d = lfsr[5:0] & (t1 ? 6'h3f : 6'h0f);
      if (d == env)
        d = d ^ 6'h01;
      put(d, w, i == bad);
      raws.push_back(t1 ? {1'b0, bits[nb-1], d} : {3'b000, bits[nb-1], d[3:0]});
      lrc = lrc ^ d;
    end
    put(env, w, 1'b0);
    lrc = lrc ^ env;
    // A bad index equal to the count spoils the check character's parity
    put(lrc ^ lrc_err, w, bad == n);
    nb = nb + 8;
  endtask

  // ****************************************
  // One card through the decoder
  // ****************************************
  task automatic run(input logic [15:0] ctrl, input logic rev, input logic [2:0] flags);
    logic [15:0] st;
    int          first;
    int          i;
    sent  = bits;
    first = 0;
    if (rev)
      for (i = 0; i < nb; i++)
        sent[i] = bits[nb-1-i];
    reg_write(stc_pkg::OFF_CTRL, ctrl);
    if (ctrl[3])
      while (first < nb && sent[first] !== 1'b1)
        first++;
    fork
      i_stc_reader_model.swipe(sent, nb);
      begin
        repeat (60) @(posedge core_clk);
        reg_read(stc_pkg::OFF_STATUS, st);
        check(st & 16'h003f, 16'h0003);
      end
    join
    i  = 0;
    st = '0;
    while (st[2] !== 1'b1 && i < 3000)
    begin
      reg_read(stc_pkg::OFF_STATUS, st);
      i++;
    end
    if (i == 3000)
    begin
      n_errors++;
      print_verdict();
    end
    if (ctrl[3] || !rev)
      check(st, {8'(raws.size()), 1'b0, rev, flags, 3'b100});
    else
      check(16'(st[5:3] != 3'b000), 16'h0001);
    reg_read(stc_pkg::OFF_BITS, st);
    check(st, 16'(nb - first));
    if (ctrl[3] || !rev)
    begin
      for (i = 0; i < raws.size(); i++)
      begin
        reg_read(stc_pkg::OFF_CHAR, st);
        check(st, exp_char(ctrl, raws[i]));
      end
      if (raws.size() > 0)
      begin
        reg_write(stc_pkg::OFF_CHAR, 16'h0000);
        reg_read(stc_pkg::OFF_CHAR, st);
        check(st, exp_char(ctrl, raws[0]));
      end
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [15:0] st;
    bit          t1;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    reg_read(stc_pkg::OFF_CTRL, st);
    check(st, 16'h0001);
    // Read data stand for one cycle only
    @(posedge core_clk);
    #1 check(reg_rdata, 16'h0000);
    reg_read(stc_pkg::OFF_BITS, st);
    check(st, 16'h0000);
    // Unmapped place: reads zero, write has no effect
    reg_write(4'h2, 16'hffff);
    reg_read(4'h2, st);
    check(st, 16'h0000);
    reg_read(stc_pkg::OFF_CTRL, st);
    check(st, 16'h0001);
    for (int m = 0; m < 4; m++)
    begin
      t1 = (modes[m][1:0] == 2'h0);
      lfsr = lfsr_next(lfsr);
      build(t1, 4 + int'(lfsr[2:0]), -1, 6'h00);
      run(modes[m], 1'b0, 3'b000);
      build(t1, 5, 2, 6'h00);
      run(modes[m], 1'b0, 3'b001);
      build(t1, 5, -1, 6'h01);
      run(modes[m], 1'b0, 3'b010);
    end
    // Check character with its own parity wrong
    build(1'b0, 5, 5, 6'h00);
    run(16'h0001, 1'b0, 3'b001);
    // Reverse swipe, with and without the retry in the other direction
    build(1'b0, 6, -1, 6'h00);
    run(16'h0009, 1'b1, 3'b000);
    build(1'b1, 6, -1, 6'h00);
    run(16'h0000, 1'b1, 3'b000);
    // Blank track: zeros only, no marker to find
    bits = '0;
    nb   = 60;
    raws.delete();
    run(16'h0001, 1'b0, 3'b100);
    print_verdict();
  end
endmodule
